//--- tb/wake_on_radio_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module wake_on_radio_timer_tb;
  logic                 ref_clk;
  logic                 resetn;
  logic                 reg_wr;
  logic [5:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic [7:0]           reg_rdata;
  logic                 reg_hit;
  wor_pkg::wor_ctrl_t   ctrl;
  wor_pkg::wor_status_t status;
  int                   bad_count;
  int                   num_checks;
  int                   n;
  int                   d;
  logic [5:0]           a;
  logic [7:0]           v;
  logic [7:0]           mreg [3];
  int                   dly [8] = '{4, 6, 8, 12, 16, 24, 32, 48};
  int                   codes [$] = '{0, 1, 3};

  wor_timer u_dut (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .reg_hit   (reg_hit),
    .ctrl      (ctrl),
    .status    (status)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // model keeps the register image; bit 2 of control never sticks
  task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = dt;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    if (ad >= 6'h1e && ad <= 6'h20) begin
      mreg[int'(ad) - 30] = (ad == 6'h20) ? (dt & 8'hfb) : dt;
    end
  endtask

  task automatic rd(input logic [5:0] ad, input logic [7:0] e,
                    input logic h);
    @(negedge ref_clk);
    reg_addr = ad;
    @(negedge ref_clk);
    chk(32'(reg_rdata), 32'(e));
    chk(32'(reg_hit), 32'(h));
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? status.first_event :
           s == 1 ? status.second_event : status.calibrating;
  endfunction

  // counts falling edges, so n is an exact cycle distance
  task automatic wait_bit(input int s, input logic val, input int bound);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > bound) begin
        bad_count++;
        give_verdict();
      end
    end while (pick(s) !== val);
  endtask

  // rc divider restarts from zero at power-up; still allow a few clocks of slack
  function automatic logic near(input int m, input int e);
    return m >= e - 8 && m <= e + 8;
  endfunction

  initial begin
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    resetn = 1'b0;
    bad_count = 0;
    num_checks = 0;
    mreg = '{8'h87, 8'h6b, 8'hf8};
    v = 8'($urandom(32'hd5abf0fb));
    repeat (3) @(negedge ref_clk);
    chk(32'(reg_rdata), 32'h0);
    chk(32'(ctrl), 32'h7c);
    resetn = 1'b1;
    for (int i = 0; i < 3; i++) rd(6'(30 + i), mreg[i], 1'b1);
    rd(6'h21 + 6'(v % 8'd31), 8'h00, 1'b0);
    repeat (6) begin
      a = 6'h1e + 6'($urandom % 5);
      v = 8'($urandom);
      if (a == 6'h20) v[7] = 1'b1;
      wr(a, v);
      for (int i = 0; i < 3; i++) rd(6'(30 + i), mreg[i], 1'b1);
    end
    for (int c = 0; c < 8; c++) begin
      wr(6'h20, {1'b1, 3'(c), 1'b1, 1'b1, 2'(c)});
      chk(32'(ctrl), 32'({1'b1, 3'(c), 1'b1, 2'(c)}));
      rd(6'h20, mreg[2], 1'b1);
    end
    wr(6'h1e, 8'h00);
    wr(6'h1f, 8'h0d);
    wr(6'h20, 8'h08);
    chk(32'(status.rc_running), 32'h1);
    wait_bit(2, 1'b1, 20);
    wait_bit(2, 1'b0, 7000);
    chk(32'(near(n, 8 * 750)), 32'h1);
    foreach (codes[i]) begin
      d = dly[codes[i]];
      wr(6'h20, {1'b0, 3'(codes[i]), 4'h0});
      wait_bit(0, 1'b1, 13 * 750 + 50);
      wait_bit(1, 1'b1, 49 * 750);
      chk(32'(n), 32'(d * 750));
      wait_bit(0, 1'b1, 13 * 750);
      chk(32'(n), 32'((13 - d) * 750));
    end
    wr(6'h20, 8'h80);
    chk(32'(status.rc_running), 32'h0);
    wr(6'h1f, 8'h01);
    wr(6'h20, 8'h01);
    wait_bit(0, 1'b1, 25000);
    chk(32'(near(n, 32 * 750)), 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/wor_pkg.sv
`default_nettype none
package wor_pkg;
  localparam logic [5:0] WOR_ADDR_TIMEOUT_HI = 6'h1e;
  localparam logic [5:0] WOR_ADDR_TIMEOUT_LO = 6'h1f;
  localparam logic [5:0] WOR_ADDR_CONTROL    = 6'h20;

  localparam logic [7:0] WOR_RST_TIMEOUT_HI = 8'h87;
  localparam logic [7:0] WOR_RST_TIMEOUT_LO = 8'h6b;

  // control register field positions
  localparam int WOR_POS_POWER_DOWN = 7;
  localparam int WOR_POS_DELAY_CODE = 4;
  localparam int WOR_POS_CAL_ENABLE = 3;
  localparam int WOR_POS_RESOLUTION = 0;

  localparam logic       WOR_RST_POWER_DOWN = 1'b1;
  localparam logic [2:0] WOR_RST_DELAY_CODE = 3'h7;
  localparam logic       WOR_RST_CAL_ENABLE = 1'b1;
  localparam logic [1:0] WOR_RST_RESOLUTION = 2'h0;

  // rc clock is the crystal divided by this
  localparam int         WOR_RC_DIVIDE  = 750;
  localparam logic [9:0] WOR_RC_DIV_MAX = 10'(WOR_RC_DIVIDE - 1);

  // rc periods spent calibrating after power-up
  localparam logic [3:0] WOR_CAL_PERIODS = 4'h8;

  typedef struct packed {
    logic       power_down;
    logic [2:0] delay_code;
    logic       cal_enable;
    logic [1:0] resolution;
  } wor_ctrl_t;

  typedef struct packed {
    logic       first_event;
    logic       second_event;
    logic       calibrating;
    logic       rc_running;
  } wor_status_t;
endpackage
`default_nettype wire

//--- verilog/wor_rc_divider.sv
`timescale 1ns/10ps
`default_nettype none
module wor_rc_divider (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic run,
  output logic      rc_tick
);
  logic [9:0] div_reg;
  logic [9:0] div_next;
  logic       tick_reg;
  logic       tick_next;

  always_comb begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (!run) begin
      div_next = 10'h000;
    end else if (div_reg == wor_pkg::WOR_RC_DIV_MAX) begin
      div_next  = 10'h000;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + 10'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg  <= 10'h000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign rc_tick = tick_reg;

  a_tick_period: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    tick_reg |=> !tick_reg)
    else $error("rc tick lasted more than one cycle");
endmodule
`default_nettype wire

//--- verilog/wor_timer.sv
`timescale 1ns/10ps
`default_nettype none
module wor_timer (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                reg_wr,
  input  wire logic [5:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_hit,
  output wor_pkg::wor_ctrl_t       ctrl,
  output wor_pkg::wor_status_t     status
);
  typedef enum logic [1:0] {WOR_OFF, WOR_CAL, WOR_WAIT0, WOR_WAIT1}
    wor_state_t;

  function automatic logic [5:0] wor_delay(input logic [2:0] code);
    case (code)
      3'h0: wor_delay = 6'h04;
      3'h1: wor_delay = 6'h06;
      3'h2: wor_delay = 6'h08;
      3'h3: wor_delay = 6'h0c;
      3'h4: wor_delay = 6'h10;
      3'h5: wor_delay = 6'h18;
      3'h6: wor_delay = 6'h20;
      default: wor_delay = 6'h30;
    endcase
  endfunction

  function automatic logic [30:0] wor_scale(input logic [15:0] t,
                                            input logic [1:0]  res);
    wor_scale = {15'h0000, t} << (5 * res);
  endfunction

  logic [7:0]          hi_reg;
  logic [7:0]          hi_next;
  logic [7:0]          lo_reg;
  logic [7:0]          lo_next;
  wor_pkg::wor_ctrl_t  ctrl_reg;
  wor_pkg::wor_ctrl_t  ctrl_next;
  wor_state_t          st_reg;
  wor_state_t          st_next;
  logic [30:0]         cnt_reg;
  logic [30:0]         cnt_next;
  logic                ev0_reg;
  logic                ev0_next;
  logic                ev1_reg;
  logic                ev1_next;
  logic [7:0]          rd_reg;
  logic [7:0]          rd_next;
  logic                rc_tick;
  logic [30:0]         target;

  wor_rc_divider u_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     (!ctrl_reg.power_down),
    .rc_tick (rc_tick)
  );

  assign target = wor_scale({hi_reg, lo_reg}, ctrl_reg.resolution);

  always_comb begin
    hi_next   = hi_reg;
    lo_next   = lo_reg;
    ctrl_next = ctrl_reg;
    if (reg_wr) begin
      case (reg_addr)
        wor_pkg::WOR_ADDR_TIMEOUT_HI: hi_next = reg_wdata;
        wor_pkg::WOR_ADDR_TIMEOUT_LO: lo_next = reg_wdata;
        wor_pkg::WOR_ADDR_CONTROL: begin
          ctrl_next.power_down = reg_wdata[wor_pkg::WOR_POS_POWER_DOWN];
          ctrl_next.delay_code =
            reg_wdata[wor_pkg::WOR_POS_DELAY_CODE +: 3];
          ctrl_next.cal_enable = reg_wdata[wor_pkg::WOR_POS_CAL_ENABLE];
          ctrl_next.resolution =
            reg_wdata[wor_pkg::WOR_POS_RESOLUTION +: 2];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_next = 8'h00;
    case (reg_addr)
      wor_pkg::WOR_ADDR_TIMEOUT_HI: rd_next = hi_reg;
      wor_pkg::WOR_ADDR_TIMEOUT_LO: rd_next = lo_reg;
      // bit 2 always reads zero
      wor_pkg::WOR_ADDR_CONTROL: rd_next = {ctrl_reg.power_down,
        ctrl_reg.delay_code, ctrl_reg.cal_enable, 1'b0,
        ctrl_reg.resolution};
      default: rd_next = 8'h00;
    endcase
  end

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    ev0_next = 1'b0;
    ev1_next = 1'b0;
    case (st_reg)
      WOR_OFF: begin
        cnt_next = 31'h0;
        if (!ctrl_reg.power_down) begin
          // skip calibration when disabled, oscillator uses last trim
          st_next = ctrl_reg.cal_enable ? WOR_CAL : WOR_WAIT0;
        end
      end
      WOR_CAL: begin
        if (rc_tick) begin
          cnt_next = cnt_reg + 31'h1;
          if (cnt_reg[3:0] == wor_pkg::WOR_CAL_PERIODS - 4'h1) begin
            cnt_next = 31'h0;
            st_next  = WOR_WAIT0;
          end
        end
      end
      WOR_WAIT0: begin
        if (rc_tick) begin
          cnt_next = cnt_reg + 31'h1;
          // zero timeout fires on the first period in WAIT0 rather than never
          if (cnt_reg + 31'h1 >= target) begin
            ev0_next = 1'b1;
            cnt_next = 31'h0;
            st_next  = WOR_WAIT1;
          end
        end
      end
      WOR_WAIT1: begin
        if (rc_tick) begin
          cnt_next = cnt_reg + 31'h1;
          // the second event's periods also count toward the next timeout
          if (cnt_reg[5:0] + 6'h01 == wor_delay(ctrl_reg.delay_code)) begin
            ev1_next = 1'b1;
            st_next  = WOR_WAIT0;
          end
        end
      end
      default: st_next = WOR_OFF;
    endcase
    if (ctrl_reg.power_down) begin
      // a tick still in flight must not leak an event after power-down
      st_next  = WOR_OFF;
      cnt_next = 31'h0;
      ev0_next = 1'b0;
      ev1_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hi_reg     <= wor_pkg::WOR_RST_TIMEOUT_HI;
      lo_reg     <= wor_pkg::WOR_RST_TIMEOUT_LO;
      ctrl_reg.power_down <= wor_pkg::WOR_RST_POWER_DOWN;
      ctrl_reg.delay_code <= wor_pkg::WOR_RST_DELAY_CODE;
      ctrl_reg.cal_enable <= wor_pkg::WOR_RST_CAL_ENABLE;
      ctrl_reg.resolution <= wor_pkg::WOR_RST_RESOLUTION;
      st_reg     <= WOR_OFF;
      cnt_reg    <= 31'h0;
      ev0_reg    <= 1'b0;
      ev1_reg    <= 1'b0;
      rd_reg     <= 8'h00;
    end else begin
      hi_reg     <= hi_next;
      lo_reg     <= lo_next;
      ctrl_reg   <= ctrl_next;
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      ev0_reg    <= ev0_next;
      ev1_reg    <= ev1_next;
      rd_reg     <= rd_next;
    end
  end

  assign reg_rdata = rd_reg;
  assign reg_hit   = (reg_addr == wor_pkg::WOR_ADDR_TIMEOUT_HI) ||
                     (reg_addr == wor_pkg::WOR_ADDR_TIMEOUT_LO) ||
                     (reg_addr == wor_pkg::WOR_ADDR_CONTROL);
  assign ctrl      = ctrl_reg;
  assign status.first_event  = ev0_reg;
  assign status.second_event = ev1_reg;
  assign status.calibrating  = (st_reg == WOR_CAL);
  assign status.rc_running   = !ctrl_reg.power_down;

  a_pd_stops_events: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ctrl_reg.power_down[*2] |-> !ev0_reg && !ev1_reg)
    else $error("event while rc oscillator powered down");
  a_cal_on_wake: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $fell(ctrl_reg.power_down) && ctrl_reg.cal_enable |=> st_reg == WOR_CAL)
    else $error("no calibration after power-up");
  a_no_cal_off: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $fell(ctrl_reg.power_down) && !ctrl_reg.cal_enable
      |=> st_reg == WOR_WAIT0)
    else $error("calibration ran while disabled");
  a_bit2_zero: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $past(reg_addr) == wor_pkg::WOR_ADDR_CONTROL |-> !reg_rdata[2])
    else $error("control bit 2 read nonzero");
  a_ev1_follows: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ev1_reg |-> $past(st_reg) == WOR_WAIT1)
    else $error("second event without first");
  a_ev0_count: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ev0_reg |-> $past(cnt_reg) + 31'h1 >= $past(target))
    else $error("first event before timeout");
  a_ev0_restart: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ev0_reg |-> st_reg == WOR_WAIT1 || ctrl_reg.power_down)
    else $error("timer did not move to second event");
  a_wr_hi: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    reg_wr && reg_addr == wor_pkg::WOR_ADDR_TIMEOUT_HI
      |=> hi_reg == $past(reg_wdata))
    else $error("high byte write lost");
endmodule
`default_nettype wire
